/* File: design/vdec_vc1_regs_pkg.sv */
// Package: register map, field masks and carrier types of the VC-1 stream register bank
package vdec_vc1_regs_pkg;

  // Register byte addresses
  localparam logic [31:0] STREAM_BUFFER_INFO_ADDR    = 32'h0090_0018;
  localparam logic [31:0] VC1_PICTURE_CONTROL_ADDR   = 32'h0090_001C;
  localparam logic [31:0] VC1_BPIC_DIST_SCALE_ADDR   = 32'h0090_0020;
  localparam logic [31:0] INTENSITY_COMP_SET0_ADDR   = 32'h0090_0024;
  localparam logic [31:0] INTENSITY_COMP_SET1_ADDR   = 32'h0090_0028;
  localparam logic [31:0] INTENSITY_COMP_SET2_ADDR   = 32'h0090_002C;
  localparam logic [31:0] STREAM_DATA_POINTER_ADDR   = 32'h0090_0030;

  // Writable bit masks; all other bits read as zero
  localparam logic [31:0] STREAM_BUFFER_INFO_MASK    = 32'hFFFF_FFFF;
  localparam logic [31:0] VC1_PICTURE_CONTROL_MASK   = 32'hFFFF_DF60;
  localparam logic [31:0] VC1_BPIC_DIST_SCALE_MASK   = 32'hFFFF_C000;
  localparam logic [31:0] INTENSITY_COMP_MASK        = 32'h01FF_FFFF;
  localparam logic [31:0] STREAM_DATA_POINTER_MASK   = 32'hFFFF_FFFC;

  localparam logic [31:0] REG_RESET                  = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY                  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR                = 2'h2;

  // Frame transform type codes
  localparam logic [1:0]  XFORM_8X8                  = 2'h0;
  localparam logic [1:0]  XFORM_8X4                  = 2'h1;
  localparam logic [1:0]  XFORM_4X8                  = 2'h2;
  localparam logic [1:0]  XFORM_4X4                  = 2'h3;

  // Alternative quantizer edge codes
  localparam logic [3:0]  EDGE_LEFT                  = 4'h0;
  localparam logic [3:0]  EDGE_TOP                   = 4'h2;
  localparam logic [3:0]  EDGE_RIGHT                 = 4'h4;
  localparam logic [3:0]  EDGE_BOTTOM                = 4'h8;

  typedef struct packed {
    logic        start_code_present;
    logic [6:0]  starting_quantizer;
    logic [23:0] input_byte_count;
  } stream_buffer_info_t;

  typedef struct packed {
    logic        bitplane_enable_a;
    logic        bitplane_enable_b;
    logic        bitplane_enable_c;
    logic [4:0]  alternative_quantizer;
    logic [3:0]  quantized_edge;
    logic        picture_level_transform_flag;
    logic [4:0]  quantizer_index;
    logic        rsvd13;
    logic        interpolation_select;
    logic        uniform_quantizer_on;
    logic        half_step_quantizer;
    logic [1:0]  frame_transform_type;
    logic        rsvd7;
    logic        variable_quantizer_on;
    logic        advanced_profile_on;
    logic [4:0]  rsvd4_0;
  } vc1_picture_control_t;

  typedef struct packed {
    logic [7:0]  direct_scale;
    logic [4:0]  forward_distance;
    logic [4:0]  backward_distance;
    logic [13:0] rsvd;
  } vc1_bpicture_distance_scale_t;

  typedef struct packed {
    logic [6:0]  rsvd;
    logic        intensity_enable;
    logic [7:0]  intensity_gain;
    logic [15:0] intensity_offset;
  } intensity_comp_t;

endpackage : vdec_vc1_regs_pkg

/* File: design/vdec_vc1_regs.sv */
// Module: AXI4-Lite register bank for stream buffer and VC-1 picture controls
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Low 24 bits hold buffer byte count
// - Exhausted buffer flags refill until new size
// - Bits 30..24 give starting quantizer
// - Bit 31 says start codes present
// - Bit 5 enables advanced profile
// - Bit 6 enables varying and alternative quantizer
// - Transform codes 8x8 8x4 4x8 4x4
// - Bit 10 enables half-step quantizer
// - Bit 11 selects uniform quantizer
// - Bit 12 selects bilinear over bicubic
// - Quantizer index feeds picture quantizer
// - Transform flag: macroblock or picture level
// - Edge field names alternative-quantizer edge
// - Bits 31..29 enable three bitplanes
// - Direct scale used only for B pictures
// - Reference distances; backward for B pictures
// - Intensity enable, gain, offset per set
// - Run-length base, low two bits unused
// - Stream byte address plus start bit
// - Write back last byte address, not JPEG
// - Also write back on error or unordered
// - Input select: stream or run-length data
// - Start bit locates first decoded bit
module vdec_vc1_regs (
  // Clock and reset
  input  wire logic                                          core_clk,
  input  wire logic                                          rst_n,
  // AXI4-Lite write address and data
  input  wire logic [31:0]                                   s_axi_awaddr,
  input  wire logic                                          s_axi_awvalid,
  output logic                                               s_axi_awready,
  input  wire logic [31:0]                                   s_axi_wdata,
  input  wire logic [3:0]                                    s_axi_wstrb,
  input  wire logic                                          s_axi_wvalid,
  output logic                                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                                         s_axi_bresp,
  output logic                                               s_axi_bvalid,
  input  wire logic                                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]                                   s_axi_araddr,
  input  wire logic                                          s_axi_arvalid,
  output logic                                               s_axi_arready,
  output logic [31:0]                                        s_axi_rdata,
  output logic [1:0]                                         s_axi_rresp,
  output logic                                               s_axi_rvalid,
  input  wire logic                                          s_axi_rready,
  // Decoder core status
  input  wire logic                                          ptrUpdate,
  input  wire logic [31:0]                                   ptrUpdateAddr,
  input  wire logic                                          inputExhaustedFlag,
  input  wire logic                                          runCompleteFlag,
  input  wire logic                                          streamErrorFlag,
  input  wire logic                                          unorderedSliceFlag,
  input  wire logic                                          decodeIsJpeg,
  input  wire logic                                          pictureIsB,
  input  wire logic                                          runLengthInputSelect,
  input  wire logic [5:0]                                    streamStartBit,
  // Decoder core controls
  output vdec_vc1_regs_pkg::stream_buffer_info_t             bufferInfo,
  output vdec_vc1_regs_pkg::vc1_picture_control_t            pictureControl,
  output vdec_vc1_regs_pkg::vc1_bpicture_distance_scale_t    distanceScale,
  output vdec_vc1_regs_pkg::intensity_comp_t                 intensitySet0,
  output vdec_vc1_regs_pkg::intensity_comp_t                 intensitySet1,
  output vdec_vc1_regs_pkg::intensity_comp_t                 intensitySet2,
  output logic [4:0]                                         altQuantizerActive,
  output logic [7:0]                                         directScaleActive,
  output logic [4:0]                                         backwardDistanceActive,
  output logic [31:0]                                        runLengthBase,
  output logic [31:0]                                        streamByteAddr,
  output logic [5:0]                                         streamFirstBit,
  output logic                                               bufferRefillNeeded
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] bufferInfoFf;
  logic [31:0] pictureControlFf;
  logic [31:0] distanceScaleFf;
  logic [31:0] intensitySet0Ff;
  logic [31:0] intensitySet1Ff;
  logic [31:0] intensitySet2Ff;
  logic [31:0] dataPointerFf;
  logic [4:0]  altQuantizerFf;
  logic [7:0]  directScaleFf;
  logic [4:0]  backwardDistFf;
  logic [31:0] runLengthBaseFf;
  logic [31:0] streamByteAddrFf;
  logic [5:0]  streamFirstBitFf;
  logic        refillNeededFf;

  // Bus state
  logic        awreadyFf;
  logic        wreadyFf;
  logic        awHeldFf;
  logic        wHeldFf;
  logic [31:0] awAddrFf;
  logic [31:0] wDataFf;
  logic [3:0]  wStrbFf;
  logic        bvalidFf;
  logic [1:0]  brespFf;
  logic        arreadyFf;
  logic        rvalidFf;
  logic [31:0] rdataFf;
  logic [1:0]  rrespFf;

  logic        takeAw;
  logic        takeW;
  logic        takeAr;
  logic        doWrite;
  logic        nxtAwHeld;
  logic        nxtWHeld;
  logic        nxtBvalid;
  logic        nxtRvalid;
  logic        writeHit;
  logic        readHit;
  logic [31:0] readWord;
  logic        ptrWriteBack;

  ////////////////////////////////////////////////////////////////////////////
  // Merge strobed bytes into a register, keeping unused bits zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Handshake control
  always_comb begin
    takeAw    = s_axi_awvalid && awreadyFf;
    takeW     = s_axi_wvalid && wreadyFf;
    takeAr    = s_axi_arvalid && arreadyFf;
    doWrite   = awHeldFf && wHeldFf && !bvalidFf;
    nxtAwHeld = (awHeldFf && !doWrite) || takeAw;
    nxtWHeld  = (wHeldFf && !doWrite) || takeW;
    nxtBvalid = (bvalidFf && !s_axi_bready) || doWrite;
    nxtRvalid = (rvalidFf && !s_axi_rready) || takeAr;
  end

  always_comb begin
    writeHit = (awAddrFf == vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_ADDR)  ||
               (awAddrFf == vdec_vc1_regs_pkg::VC1_PICTURE_CONTROL_ADDR) ||
               (awAddrFf == vdec_vc1_regs_pkg::VC1_BPIC_DIST_SCALE_ADDR) ||
               (awAddrFf == vdec_vc1_regs_pkg::INTENSITY_COMP_SET0_ADDR) ||
               (awAddrFf == vdec_vc1_regs_pkg::INTENSITY_COMP_SET1_ADDR) ||
               (awAddrFf == vdec_vc1_regs_pkg::INTENSITY_COMP_SET2_ADDR) ||
               (awAddrFf == vdec_vc1_regs_pkg::STREAM_DATA_POINTER_ADDR);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeldFf  <= 1'b0;
      wHeldFf   <= 1'b0;
      awreadyFf <= 1'b0;
      wreadyFf  <= 1'b0;
      bvalidFf  <= 1'b0;
      brespFf   <= vdec_vc1_regs_pkg::RESP_OKAY;
      awAddrFf  <= vdec_vc1_regs_pkg::REG_RESET;
      wDataFf   <= vdec_vc1_regs_pkg::REG_RESET;
      wStrbFf   <= 4'h0;
    end else begin
      awHeldFf  <= nxtAwHeld;
      wHeldFf   <= nxtWHeld;
      awreadyFf <= !nxtAwHeld && !nxtBvalid;
      wreadyFf  <= !nxtWHeld && !nxtBvalid;
      bvalidFf  <= nxtBvalid;
      if (takeAw) begin
        awAddrFf <= s_axi_awaddr;
      end
      if (takeW) begin
        wDataFf <= s_axi_wdata;
        wStrbFf <= s_axi_wstrb;
      end
      if (doWrite) begin
        brespFf <= writeHit ? vdec_vc1_regs_pkg::RESP_OKAY : vdec_vc1_regs_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufferInfoFf     <= vdec_vc1_regs_pkg::REG_RESET;
      pictureControlFf <= vdec_vc1_regs_pkg::REG_RESET;
      distanceScaleFf  <= vdec_vc1_regs_pkg::REG_RESET;
      intensitySet0Ff  <= vdec_vc1_regs_pkg::REG_RESET;
      intensitySet1Ff  <= vdec_vc1_regs_pkg::REG_RESET;
      intensitySet2Ff  <= vdec_vc1_regs_pkg::REG_RESET;
    end else if (doWrite) begin
      unique case (awAddrFf)
        vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_ADDR: begin
          bufferInfoFf <= merge(bufferInfoFf, wDataFf, wStrbFf, vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_MASK);
        end
        vdec_vc1_regs_pkg::VC1_PICTURE_CONTROL_ADDR: begin
          pictureControlFf <= merge(pictureControlFf, wDataFf, wStrbFf,
                                    vdec_vc1_regs_pkg::VC1_PICTURE_CONTROL_MASK);
        end
        vdec_vc1_regs_pkg::VC1_BPIC_DIST_SCALE_ADDR: begin
          distanceScaleFf <= merge(distanceScaleFf, wDataFf, wStrbFf, vdec_vc1_regs_pkg::VC1_BPIC_DIST_SCALE_MASK);
        end
        vdec_vc1_regs_pkg::INTENSITY_COMP_SET0_ADDR: begin
          intensitySet0Ff <= merge(intensitySet0Ff, wDataFf, wStrbFf, vdec_vc1_regs_pkg::INTENSITY_COMP_MASK);
        end
        vdec_vc1_regs_pkg::INTENSITY_COMP_SET1_ADDR: begin
          intensitySet1Ff <= merge(intensitySet1Ff, wDataFf, wStrbFf, vdec_vc1_regs_pkg::INTENSITY_COMP_MASK);
        end
        vdec_vc1_regs_pkg::INTENSITY_COMP_SET2_ADDR: begin
          intensitySet2Ff <= merge(intensitySet2Ff, wDataFf, wStrbFf, vdec_vc1_regs_pkg::INTENSITY_COMP_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pointer: hardware write-back wins over a software write
  always_comb begin
    ptrWriteBack = ptrUpdate && !decodeIsJpeg &&
                   (inputExhaustedFlag || !runCompleteFlag ||
                    streamErrorFlag || unorderedSliceFlag);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPointerFf <= vdec_vc1_regs_pkg::REG_RESET;
    end else if (ptrWriteBack) begin
      dataPointerFf <= ptrUpdateAddr & vdec_vc1_regs_pkg::STREAM_DATA_POINTER_MASK;
    end else if (doWrite && (awAddrFf == vdec_vc1_regs_pkg::STREAM_DATA_POINTER_ADDR)) begin
      dataPointerFf <= merge(dataPointerFf, wDataFf, wStrbFf, vdec_vc1_regs_pkg::STREAM_DATA_POINTER_MASK);
    end
  end

  // Refill request: exhaustion sets, a new buffer description clears, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refillNeededFf <= 1'b0;
    end else if (ptrUpdate && inputExhaustedFlag) begin
      refillNeededFf <= 1'b1;
    end else if (doWrite && (awAddrFf == vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_ADDR)) begin
      refillNeededFf <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualified controls for the decoder core
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      altQuantizerFf   <= 5'h0;
      directScaleFf    <= 8'h00;
      backwardDistFf   <= 5'h0;
      runLengthBaseFf  <= vdec_vc1_regs_pkg::REG_RESET;
      streamByteAddrFf <= vdec_vc1_regs_pkg::REG_RESET;
      streamFirstBitFf <= 6'h00;
    end else begin
      altQuantizerFf   <= pictureControl.variable_quantizer_on ? pictureControl.alternative_quantizer : 5'h0;
      directScaleFf    <= pictureIsB ? distanceScale.direct_scale : 8'h00;
      backwardDistFf   <= pictureIsB ? distanceScale.backward_distance : 5'h0;
      runLengthBaseFf  <= runLengthInputSelect ? dataPointerFf : vdec_vc1_regs_pkg::REG_RESET;
      streamByteAddrFf <= runLengthInputSelect ? vdec_vc1_regs_pkg::REG_RESET : dataPointerFf;
      streamFirstBitFf <= runLengthInputSelect ? 6'h00 : streamStartBit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    readHit  = 1'b1;
    readWord = vdec_vc1_regs_pkg::REG_RESET;
    unique case (s_axi_araddr)
      vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_ADDR:  readWord = bufferInfoFf;
      vdec_vc1_regs_pkg::VC1_PICTURE_CONTROL_ADDR: readWord = pictureControlFf;
      vdec_vc1_regs_pkg::VC1_BPIC_DIST_SCALE_ADDR: readWord = distanceScaleFf;
      vdec_vc1_regs_pkg::INTENSITY_COMP_SET0_ADDR: readWord = intensitySet0Ff;
      vdec_vc1_regs_pkg::INTENSITY_COMP_SET1_ADDR: readWord = intensitySet1Ff;
      vdec_vc1_regs_pkg::INTENSITY_COMP_SET2_ADDR: readWord = intensitySet2Ff;
      vdec_vc1_regs_pkg::STREAM_DATA_POINTER_ADDR: readWord = dataPointerFf;
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arreadyFf <= 1'b0;
      rvalidFf  <= 1'b0;
      rdataFf   <= vdec_vc1_regs_pkg::REG_RESET;
      rrespFf   <= vdec_vc1_regs_pkg::RESP_OKAY;
    end else begin
      arreadyFf <= !nxtRvalid;
      rvalidFf  <= nxtRvalid;
      if (takeAr) begin
        rdataFf <= readWord;
        rrespFf <= readHit ? vdec_vc1_regs_pkg::RESP_OKAY : vdec_vc1_regs_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready          = awreadyFf;
  assign s_axi_wready           = wreadyFf;
  assign s_axi_bvalid           = bvalidFf;
  assign s_axi_bresp            = brespFf;
  assign s_axi_arready          = arreadyFf;
  assign s_axi_rvalid           = rvalidFf;
  assign s_axi_rdata            = rdataFf;
  assign s_axi_rresp            = rrespFf;
  assign bufferInfo             = bufferInfoFf;
  assign pictureControl         = pictureControlFf;
  assign distanceScale          = distanceScaleFf;
  assign intensitySet0          = intensitySet0Ff;
  assign intensitySet1          = intensitySet1Ff;
  assign intensitySet2          = intensitySet2Ff;
  assign altQuantizerActive     = altQuantizerFf;
  assign directScaleActive      = directScaleFf;
  assign backwardDistanceActive = backwardDistFf;
  assign runLengthBase          = runLengthBaseFf;
  assign streamByteAddr         = streamByteAddrFf;
  assign streamFirstBit         = streamFirstBitFf;
  assign bufferRefillNeeded     = refillNeededFf;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_bvalid_hold: assert property (bvalidFf && !s_axi_bready |=> bvalidFf)
    else $error("write response dropped before bready");
  chk_rvalid_hold: assert property (rvalidFf && !s_axi_rready |=> rvalidFf && $stable(rdataFf))
    else $error("read data changed before rready");
  chk_write_resp: assert property (doWrite |=> bvalidFf && !awreadyFf && !wreadyFf)
    else $error("write did not answer one cycle later");
  chk_ptr_writeback: assert property (ptrWriteBack |=> dataPointerFf == ($past(ptrUpdateAddr) & 32'hFFFF_FFFC))
    else $error("data pointer missed hardware write-back");
  chk_ptr_jpeg_skip: assert property (ptrUpdate && decodeIsJpeg && !doWrite |=> $stable(dataPointerFf))
    else $error("data pointer written back in jpeg mode");
  chk_ptr_err_wb: assert property (ptrUpdate && !decodeIsJpeg && streamErrorFlag
                                   |=> dataPointerFf[31:2] == $past(ptrUpdateAddr[31:2]))
    else $error("error write-back missing");
  chk_ptr_low_zero: assert property (dataPointerFf[1:0] == 2'h0 && runLengthBaseFf[1:0] == 2'h0)
    else $error("pointer low bits not zero");
  chk_refill_set: assert property (ptrUpdate && inputExhaustedFlag |=> refillNeededFf [*2] or
                                   (refillNeededFf ##1 1'b1))
    else $error("refill request not raised");
  chk_bscale_gate: assert property (!pictureIsB |=> directScaleFf == 8'h00 && backwardDistFf == 5'h0)
    else $error("B-only field active outside B picture");
  chk_altq_gate: assert property (!pictureControl.variable_quantizer_on |=> altQuantizerFf == 5'h0)
    else $error("alternative quantizer active while fixed");
  chk_ctrl_rsvd: assert property ((pictureControlFf & ~32'hFFFF_DF60) == 32'h0 &&
                                  (distanceScaleFf & ~32'hFFFF_C000) == 32'h0)
    else $error("reserved control bits set");

  cov_write: cover property (doWrite ##1 bvalidFf && s_axi_bready);
  cov_read: cover property (takeAr ##1 rvalidFf && s_axi_rready);
  cov_writeback: cover property (ptrWriteBack && doWrite);
  cov_refill: cover property (refillNeededFf ##[1:20] !refillNeededFf);

endmodule : vdec_vc1_regs
`default_nettype wire

/* File: bench/testbench.sv */
// Testbench: register bus, field and pointer write-back checks of the VC-1 register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] BASE = vdec_vc1_regs_pkg::STREAM_BUFFER_INFO_ADDR;
  logic core_clk, rst_n, ptrUpdate, inputExhaustedFlag, runCompleteFlag, streamErrorFlag, unorderedSliceFlag;
  logic decodeIsJpeg, pictureIsB, runLengthInputSelect, bufferRefillNeeded;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, ptrUpdateAddr, runLengthBase, streamByteAddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] streamStartBit, streamFirstBit;
  logic [4:0] altQuantizerActive, backwardDistanceActive;
  logic [7:0] directScaleActive;
  logic [31:0] rd, last;
  vdec_vc1_regs_pkg::stream_buffer_info_t bufferInfo;
  vdec_vc1_regs_pkg::vc1_picture_control_t pictureControl;
  vdec_vc1_regs_pkg::vc1_bpicture_distance_scale_t distanceScale;
  vdec_vc1_regs_pkg::intensity_comp_t intensitySet0, intensitySet1, intensitySet2;
  logic [31:0] msk [7] = '{32'hFFFF_FFFF, 32'hFFFF_DF60, 32'hFFFF_C000, 32'h01FF_FFFF, 32'h01FF_FFFF,
                           32'h01FF_FFFF, 32'hFFFF_FFFC};
  logic [3:0] edg [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
  logic [4:0] fl [5] = '{5'b0_0010, 5'b1_0001, 5'b0_0110, 5'b0_1010, 5'b0_0000};
  int numErrors, testsRun, i;

  vdec_vc1_regs dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ptrUpdate(ptrUpdate), .ptrUpdateAddr(ptrUpdateAddr), .inputExhaustedFlag(inputExhaustedFlag),
    .runCompleteFlag(runCompleteFlag), .streamErrorFlag(streamErrorFlag), .unorderedSliceFlag(unorderedSliceFlag),
    .decodeIsJpeg(decodeIsJpeg), .pictureIsB(pictureIsB), .runLengthInputSelect(runLengthInputSelect),
    .streamStartBit(streamStartBit), .bufferInfo(bufferInfo), .pictureControl(pictureControl),
    .distanceScale(distanceScale), .intensitySet0(intensitySet0), .intensitySet1(intensitySet1),
    .intensitySet2(intensitySet2), .altQuantizerActive(altQuantizerActive), .directScaleActive(directScaleActive),
    .backwardDistanceActive(backwardDistanceActive), .runLengthBase(runLengthBase), .streamByteAddr(streamByteAddr),
    .streamFirstBit(streamFirstBit), .bufferRefillNeeded(bufferRefillNeeded));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      numErrors++;
      wrap_up();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      numErrors++;
      wrap_up();
    end
  endtask : axi_rd

  // One write-back strobe; flags are {jpeg, unordered, error, done, exhausted}
  task automatic core_upd(input logic [31:0] a, input logic [4:0] f);
    @(posedge core_clk);
    ptrUpdate <= 1'b1;
    ptrUpdateAddr <= a;
    {decodeIsJpeg, unorderedSliceFlag, streamErrorFlag, runCompleteFlag, inputExhaustedFlag} <= f;
    @(posedge core_clk);
    ptrUpdate <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : core_upd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, ptrUpdate, inputExhaustedFlag, streamErrorFlag, unorderedSliceFlag, decodeIsJpeg, pictureIsB} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, runLengthInputSelect} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, ptrUpdateAddr, streamStartBit} = '0;
    runCompleteFlag = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 7; i++) begin
      axi_rd(BASE + 4 * i, rd, rs);
      check(rd, 32'h0);
      axi_wr(BASE + 4 * i, 32'hFFFF_FFFF, rs);
      axi_rd(BASE + 4 * i, rd, rs);
      check(rd, msk[i]);
    end
    axi_wr(32'h0090_0034, 32'h1, rs);
    check(rs, 2'h2);
    axi_rd(32'h0090_0034, rd, rs);
    check(rd, 32'h0);
    check(rs, 2'h2);
    $display("test register map finished");
    axi_wr(BASE, 32'h9A12_3456, rs);
    check(bufferInfo.input_byte_count, 24'h12_3456);
    check(bufferInfo.starting_quantizer, 7'h1A);
    check(bufferInfo.start_code_present, 1'b1);
    for (i = 0; i < 4; i++) begin
      axi_wr(BASE + 4, {3'b101, 5'h15, edg[i], 1'b1, 5'h0B, 1'b0, 3'b111, i[1:0], 1'b0, i[0], 1'b1, 5'h0}, rs);
      repeat (3) @(posedge core_clk);
      check(pictureControl.frame_transform_type, i[1:0]);
      check(pictureControl.quantized_edge, edg[i]);
      check(pictureControl.quantizer_index, 5'h0B);
      check({pictureControl.bitplane_enable_a, pictureControl.interpolation_select,
             pictureControl.advanced_profile_on}, 3'h7);
      check(altQuantizerActive, i[0] ? 5'h15 : 5'h00);
    end
    axi_wr(BASE + 8, 32'hA58A_C000, rs);
    repeat (3) @(posedge core_clk);
    check({directScaleActive, backwardDistanceActive}, 13'h0);
    pictureIsB <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({directScaleActive, backwardDistanceActive}, {8'hA5, 5'h0B});
    check(distanceScale.forward_distance, 5'h11);
    axi_wr(BASE + 16, 32'h01AB_1234, rs);
    check(intensitySet1, 32'h01AB_1234);
    check(intensitySet0, 32'h01FF_FFFF);
    s_axi_wstrb <= 4'h2;
    axi_wr(BASE + 20, 32'h0, rs);
    s_axi_wstrb <= 4'hF;
    check(intensitySet2, 32'h01FF_00FF);
    $display("test picture fields finished");
    streamStartBit <= 6'h2D;
    core_upd(32'h1234_5677, 5'b0_0011);
    axi_rd(BASE + 24, rd, rs);
    check(rd, 32'h1234_5674);
    check(bufferRefillNeeded, 1'b1);
    check(streamByteAddr, 32'h1234_5674);
    check(streamFirstBit, 6'h2D);
    check(runLengthBase, 32'h0);
    axi_wr(BASE, 32'h0000_0100, rs);
    repeat (2) @(posedge core_clk);
    check(bufferRefillNeeded, 1'b0);
    last = 32'h1234_5674;
    for (i = 0; i < 5; i++) begin
      core_upd(32'h0055_0101 + (i << 8), fl[i]);
      if (i >= 2) last = 32'h0055_0100 + (i << 8);
      axi_rd(BASE + 24, rd, rs);
      check(rd, last);
    end
    runLengthInputSelect <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(runLengthBase, last);
    check(streamByteAddr, 32'h0);
    $display("test pointer write-back finished");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
